// ### hw/temp_seq_pkg.sv
package temp_seq_pkg;
  localparam int unsigned  PHASE_DIV        = 4;
  localparam logic [1:0]   PHASE_LAST       = 2'h3;
  localparam int unsigned  SAMPLES_PER_CONV = 255;
  localparam logic [7:0]   SAMPLE_LOAD      = 8'hff;
  localparam logic [7:0]   COUNT_CLEAR      = 8'h00;
  localparam logic [7:0]   RESULT_RESET     = 8'h00;
  localparam logic signed [15:0] SAT_MAX    = 16'sh007f;
  localparam logic signed [15:0] SAT_MIN    = -16'sh0080;
  localparam int unsigned  SCALE_FRAC_BITS  = 4;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_type;
endpackage : temp_seq_pkg

// ### hw/phase_divider.sv
`timescale 1ns/1ps
// sampling phase from column clock enable pulses
module phase_divider (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic run_in,
  input  wire logic col_tick_in,
  output logic      phase_level_out,
  output logic      phase_fall_out
);
  logic [1:0] div_ff;
  logic [1:0] nxt_div;

  always_comb begin
    nxt_div = div_ff;
    if (!run_in) begin
      nxt_div = 2'h0;
    end else if (col_tick_in) begin
      nxt_div = div_ff + 2'h1; // RQ1
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // phase high for the first two column cycles of each four
  assign phase_level_out = run_in && !div_ff[1];
  // phase ends when the divider steps from 1 into its high half
  assign phase_fall_out  = run_in && col_tick_in &&
                           (div_ff == temp_seq_pkg::PHASE_LAST >> 1); // RQ2
endmodule : phase_divider

// ### hw/coarse_temp_adc_sequencer.sv
`timescale 1ns/1ps
// Operation
// RQ1 - sampling phase is column clock over four
// RQ2 - sample comparator when sampling phase falls
// RQ3 - 255 samples, count positive ones
// RQ4 - reference sign follows last comparator polarity
// RQ5 - result is 8-bit signed degrees
// RQ6 - start disables feedback cap auto reset
// RQ7 - start clears count, loads sample counter
// RQ8 - start loads trim, powers up, enables
// RQ9 - last sample stops events, powers down
// RQ10 - one start gives exactly one conversion
// RQ11 - each sample serviced within one phase
// RQ12 - host keeps column clock slow enough
// RQ13 - no other block drives comparator
// RQ14 - host starts, polls done, then reads
// RQ15 - done high only while result unread
// RQ16 - reading result clears data ready
// RQ17 - calibrate count, saturate to 8 bits
// RQ18 - register comparator before counting
module coarse_temp_adc_sequencer (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        col_clk_in,
  input  wire logic        comparator_in,
  input  wire logic        start_conversion_in,
  input  wire logic        read_temperature_result_in,
  input  wire logic [7:0]  cal_offset_in,
  input  wire logic [7:0]  cal_scale_in,
  output logic             conversion_done_poll_out,
  output logic [7:0]       temperature_out,
  output logic             busy_out,
  output logic             analog_power_out,
  output logic             feedback_reset_en_out,
  output logic             reference_select_out,
  output logic             phase_out
);
  temp_seq_pkg::seq_state_type state_ff;
  temp_seq_pkg::seq_state_type nxt_state;

  logic [2:0] col_sync_ff;
  logic [1:0] cmp_sync_ff;
  logic       cmp_sample_ff;
  logic       nxt_cmp_sample;
  logic [7:0] remain_ff;
  logic [7:0] nxt_remain;
  logic [7:0] pos_count_ff;
  logic [7:0] nxt_pos_count;
  logic [7:0] offset_ff;
  logic [7:0] nxt_offset;
  logic [7:0] scale_ff;
  logic [7:0] nxt_scale;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic       ready_ff;
  logic       nxt_ready;
  logic       col_tick;
  logic       phase_fall;
  logic       phase_level;
  logic       run;

  // count times scale (fixed point) plus signed offset, clamped
  function automatic logic [7:0] to_celsius(input logic [7:0] cnt,
                                            input logic [7:0] scl,
                                            input logic [7:0] off);
    logic signed [15:0] prod;
    logic signed [15:0] sum;
    prod = 16'(({8'h00, cnt} * {8'h00, scl})
                >> temp_seq_pkg::SCALE_FRAC_BITS);
    sum  = prod + 16'($signed(off));
    if (sum > temp_seq_pkg::SAT_MAX) begin
      to_celsius = temp_seq_pkg::SAT_MAX[7:0]; // RQ17
    end else if (sum < temp_seq_pkg::SAT_MIN) begin
      to_celsius = temp_seq_pkg::SAT_MIN[7:0]; // RQ17
    end else begin
      to_celsius = sum[7:0]; // RQ5
    end
  endfunction : to_celsius

  // column clock is a foreign pin: synchronised, then edge detected
  assign col_tick = col_sync_ff[1] && !col_sync_ff[2];
  assign run      = (state_ff == temp_seq_pkg::ST_RUN);

  phase_divider u_phase_divider (
    .core_clk_in     (core_clk_in),
    .rstn_in         (rstn_in),
    .run_in          (run),
    .col_tick_in     (col_tick),
    .phase_level_out (phase_level),
    .phase_fall_out  (phase_fall)
  );

  always_comb begin
    nxt_state      = state_ff;
    nxt_remain     = remain_ff;
    nxt_pos_count  = pos_count_ff;
    nxt_offset     = offset_ff;
    nxt_scale      = scale_ff;
    nxt_result     = result_ff;
    nxt_ready      = ready_ff;
    nxt_cmp_sample = cmp_sample_ff;
    if (read_temperature_result_in) begin
      nxt_ready = 1'b0; // RQ16
    end
    unique case (state_ff)
      temp_seq_pkg::ST_IDLE: begin
        if (start_conversion_in) begin // RQ10
          nxt_remain    = temp_seq_pkg::SAMPLE_LOAD; // RQ7
          nxt_pos_count = temp_seq_pkg::COUNT_CLEAR; // RQ7
          nxt_offset    = cal_offset_in; // RQ8
          nxt_scale     = cal_scale_in; // RQ8
          nxt_ready     = 1'b0; // RQ15
          nxt_state     = temp_seq_pkg::ST_RUN;
        end
      end
      temp_seq_pkg::ST_RUN: begin
        // one sample serviced per phase, never missed in hardware
        if (phase_fall) begin // RQ11
          nxt_cmp_sample = cmp_sync_ff[1]; // RQ2
          nxt_remain     = remain_ff - 8'h01; // RQ3
          if (remain_ff == 8'h01) begin
            nxt_state = temp_seq_pkg::ST_CONVERT; // RQ9
          end
        end
        // count and held polarity take the same synchronised level
        if (phase_fall && cmp_sync_ff[1]) begin
          nxt_pos_count = pos_count_ff + 8'h01; // RQ18
        end
      end
      temp_seq_pkg::ST_CONVERT: begin
        nxt_result = to_celsius(pos_count_ff, scale_ff, offset_ff); // RQ17
        nxt_ready  = 1'b1; // RQ15
        nxt_state  = temp_seq_pkg::ST_IDLE; // RQ10
      end
      default: begin
        nxt_state = temp_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff      <= temp_seq_pkg::ST_IDLE;
      col_sync_ff   <= 3'h0;
      cmp_sync_ff   <= 2'h0;
      cmp_sample_ff <= 1'b0;
      remain_ff     <= temp_seq_pkg::COUNT_CLEAR;
      pos_count_ff  <= temp_seq_pkg::COUNT_CLEAR;
      offset_ff     <= temp_seq_pkg::COUNT_CLEAR;
      scale_ff      <= temp_seq_pkg::COUNT_CLEAR;
      result_ff     <= temp_seq_pkg::RESULT_RESET;
      ready_ff      <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      col_sync_ff   <= {col_sync_ff[1:0], col_clk_in};
      cmp_sync_ff   <= {cmp_sync_ff[0], comparator_in}; // RQ18
      cmp_sample_ff <= nxt_cmp_sample;
      remain_ff     <= nxt_remain;
      pos_count_ff  <= nxt_pos_count; // RQ3
      offset_ff     <= nxt_offset;
      scale_ff      <= nxt_scale;
      result_ff     <= nxt_result;
      ready_ff      <= nxt_ready;
    end
  end

  assign conversion_done_poll_out = ready_ff; // RQ15
  assign temperature_out          = result_ff; // RQ5
  assign busy_out                 = (state_ff != temp_seq_pkg::ST_IDLE);
  assign analog_power_out         = run; // RQ8
  // integrating cap holds charge only while sampling in ST_RUN
  assign feedback_reset_en_out    = !run; // RQ6
  // positive integrator pulls back by subtracting reference
  assign reference_select_out     = cmp_sample_ff; // RQ4
  assign phase_out                = phase_level;
endmodule : coarse_temp_adc_sequencer

// ### bench/coarse_temp_adc_sequencer_properties.sv
`timescale 1ns/1ps
module temp_seq_checker (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       start_conversion_in,
  input  wire logic       read_temperature_result_in,
  input  wire logic       conversion_done_poll_out,
  input  wire logic [7:0] temperature_out,
  input  wire logic       busy_out,
  input  wire logic       analog_power_out,
  input  wire logic       feedback_reset_en_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  chk_fb_integrates: assert property (
    analog_power_out |-> !feedback_reset_en_out) else $error("fb reset on");
  chk_done_not_busy: assert property (
    conversion_done_poll_out |-> !busy_out) else $error("done while busy");
  chk_start_powers: assert property (
    start_conversion_in && !busy_out |=> busy_out && analog_power_out)
    else $error("start not taken");
  chk_read_clears: assert property (
    read_temperature_result_in && !busy_out |=> !conversion_done_poll_out)
    else $error("read kept done");
  chk_done_holds: assert property (
    conversion_done_poll_out && !read_temperature_result_in &&
    !start_conversion_in |=> conversion_done_poll_out) else $error("done lost");
  chk_power_down: assert property (
    $fell(analog_power_out) |-> ##[0:2] conversion_done_poll_out)
    else $error("power off without result");
  chk_one_start: assert property (
    $rose(busy_out) |-> $past(start_conversion_in)) else $error("self start");
  chk_result_holds: assert property (
    !busy_out |=> $stable(temperature_out)) else $error("result moved");
  cover property (conversion_done_poll_out && read_temperature_result_in);
  cover property ($fell(busy_out));
  cover property (start_conversion_in && busy_out);
endmodule : temp_seq_checker

// ### bench/integ_model.sv
`timescale 1ns/1ps
// integrator plus comparator; when powered, mode 1x forces the comparator level
module integ_model (
  input  wire logic       col_clk_in,
  input  wire logic       power_in,
  input  wire logic       ref_sel_in,
  input  wire logic [1:0] mode_in,
  output logic            comp_out
);
  int acc = 0;
  initial comp_out = 1'b0;
  always @(posedge col_clk_in) begin
    if (!power_in) begin
      comp_out <= ~comp_out; // unpowered, level is meaningless
    end else if (mode_in[1]) begin
      comp_out <= mode_in[0];
    end else begin
      acc = acc + 3 - (ref_sel_in ? 8 : -8);
      comp_out <= acc > 0;
    end
  end
endmodule : integ_model

// ### bench/coarse_temp_adc_sequencer_tb.sv
`timescale 1ns/1ps
module coarse_temp_adc_sequencer_tb;
  logic       core_clk_in, rstn_in, col_clk_in, comparator_in;
  logic       start_conversion_in, read_temperature_result_in;
  logic       conversion_done_poll_out, busy_out, analog_power_out;
  logic       feedback_reset_en_out, reference_select_out, phase_out;
  logic [7:0] cal_offset_in, cal_scale_in, temperature_out;
  logic [1:0] cmp_mode;
  int         errors = 0, total_checks = 0, cyc = 0;

  coarse_temp_adc_sequencer uut (.*);
  integ_model im (.col_clk_in(col_clk_in), .power_in(analog_power_out),
    .ref_sel_in(reference_select_out), .mode_in(cmp_mode),
    .comp_out(comparator_in)); // model answers every rising column edge

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    col_clk_in = 1'b0;
    #7;
    forever #20 col_clk_in = ~col_clk_in; // far below core rate
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic conv(input logic [1:0] m, input logic [7:0] s, o,
                      input int lo, hi);
    int n;
    n = 0;
    @(posedge core_clk_in);
    cmp_mode <= m;
    cal_scale_in <= s;
    cal_offset_in <= o;
    start_conversion_in <= 1'b1;
    @(posedge core_clk_in);
    start_conversion_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    check("run", 8'h1, {7'h0, busy_out & analog_power_out});
    check("integ", 8'h0, {7'h0, feedback_reset_en_out});
    while (conversion_done_poll_out !== 1'b1 && n < 9000) begin
      @(posedge core_clk_in);
      start_conversion_in <= (n == 20); // refused while busy
      #1;
      n++;
    end
    check("length", 8'h1, {7'h0, n > 8130 && n < 8176});
    check("temp", 8'h1, {7'h0, $signed(temperature_out) >= lo &&
      $signed(temperature_out) <= hi});
    check("power", 8'h0, {7'h0, analog_power_out});
    if (m[1]) check("ref", {7'h0, m[0]}, {7'h0, reference_select_out});
    repeat (5) @(posedge core_clk_in);
    #1;
    check("done", 8'h1, {7'h0, conversion_done_poll_out});
    @(posedge core_clk_in);
    read_temperature_result_in <= 1'b1;
    @(posedge core_clk_in);
    read_temperature_result_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("read", 8'h0, {7'h0, conversion_done_poll_out});
    repeat (40) @(posedge core_clk_in);
    #1;
    check("idle", 8'h0, {7'h0, busy_out | analog_power_out | phase_out});
  endtask : conv

  initial begin
    rstn_in = 1'b0;
    start_conversion_in = 1'b0;
    read_temperature_result_in = 1'b0;
    cmp_mode = 2'h3;
    cal_offset_in = 8'h00;
    cal_scale_in = 8'h00;
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    check("fb_reset", 8'h1, {7'h0, feedback_reset_en_out});
    conv(2'h3, 8'h10, 8'h00, 127, 127);
    conv(2'h2, 8'h10, 8'h80, -128, -128);
    conv(2'h3, 8'h01, 8'h0a, 25, 25);
    conv(2'h0, 8'h10, 8'h80, 37, 58);
    wrap_up();
  end
endmodule : coarse_temp_adc_sequencer_tb

bind coarse_temp_adc_sequencer temp_seq_checker chk (.*);
